// ### hw/bcc_pkg.sv
package bcc_pkg;
    localparam logic [2:0] ADDR_SEC = 3'h2;
    localparam logic [2:0] ADDR_MIN = 3'h3;
    localparam logic [2:0] ADDR_HR = 3'h4;
    localparam logic [2:0] ADDR_DAY = 3'h5;
    localparam logic [2:0] ADDR_MON = 3'h6;
    localparam logic [2:0] ADDR_CTRL = 3'h7;
    localparam int CTRL_RUN_BIT = 2;
    localparam int CTRL_ALARM_BIT = 3;
    localparam int HR_PM_BIT = 7;
    localparam int HR_12H_BIT = 6;
    localparam int MON_LEAP_BIT = 7;
    localparam int STAT_ALARM_BIT = 7;
    localparam int STAT_CLKOUT_BIT = 6;
    localparam logic [21:0] DIV_32K = 22'h00_7FFF;
    localparam logic [21:0] DIV_1M = 22'h0F_FFFF;
    localparam logic [21:0] DIV_2M = 22'h1F_FFFF;
    localparam logic [21:0] DIV_4M = 22'h3F_FFFF;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SEC_RESET = 8'h00;
    localparam logic [7:0] MIN_RESET = 8'h00;
    localparam logic [7:0] HR_RESET = 8'h00;
    localparam logic [7:0] DAY_RESET = 8'h01;
    localparam logic [7:0] MON_RESET = 8'h01;
    localparam logic [7:0] HR_ALARM_RESET = 8'h30;
    localparam logic [3:0] PEND_MAX = 4'hF;

    typedef struct packed {
        logic cs;
        logic port_sel;
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } bcc_bus_t;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hr;
        logic [7:0] day;
        logic [7:0] mon;
    } bcc_time_t;
endpackage

// ### hw/bcc_clock.sv
`timescale 1ns/1ps
module bcc_clock (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Oscillator and modes.
    input wire logic i_osc_tick,
    input wire logic i_io_mode,
    input wire logic i_power_down,
    // Processor bus.
    input wire bcc_pkg::bcc_bus_t i_bus,
    output logic [7:0] o_rdata,
    output logic o_rdata_oe,
    // Clock output and interrupt.
    output logic o_clkout,
    output logic o_irq_n
);
    import bcc_pkg::*;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction

    function automatic logic [7:0] days_in(input logic [7:0] mon);
        unique case (mon[4:0])
            5'h02: days_in = mon[MON_LEAP_BIT] ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: days_in = 8'h30;
            default: days_in = 8'h31;
        endcase
    endfunction

    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] status_reg, status_next;
    logic [7:0] rdata_reg, rdata_next;
    logic wr_q_reg, wr_q_next;
    logic irq_n_reg, irq_n_next;
    logic [21:0] presc_reg, presc_next;
    logic [3:0] pend_reg, pend_next;
    bcc_time_t time_reg, time_next;
    bcc_time_t alarm_reg, alarm_next;
    logic co_reg, co_next;
    logic match_q_reg, match_q_next;

    logic sel, access, rd_fire, wr_fire, wr_ctrl, tick, apply, sec_carry, min_carry;
    logic hr_carry, day_carry, alarm_rise, co_fall, match, wave;
    logic [21:0] div_top;
    logic [14:0] phase;
    logic [7:0] hr_n, hr_inc, mon_inc;

    assign sel = i_io_mode ? i_bus.port_sel : i_bus.cs;
    assign access = sel && (i_bus.rd || i_bus.wr) && !i_power_down;
    assign rd_fire = access && i_bus.rd;
    // A long write strobe loads once; the edge detector keeps it from reloading.
    assign wr_fire = access && i_bus.wr && !wr_q_reg;
    assign wr_ctrl = wr_fire && (i_bus.addr == ADDR_CTRL);

    // Prescaler: divisor and the 15-bit fraction of a second.
    always_comb begin
        unique case (ctrl_reg[1:0])
            2'b00: begin
                div_top = DIV_32K;
                phase = presc_reg[14:0];
            end
            2'b01: begin
                div_top = DIV_1M;
                phase = presc_reg[19:5];
            end
            2'b10: begin
                div_top = DIV_2M;
                phase = presc_reg[20:6];
            end
            2'b11: begin
                div_top = DIV_4M;
                phase = presc_reg[21:7];
            end
        endcase
        tick = i_osc_tick && (presc_reg == div_top) && ctrl_reg[CTRL_RUN_BIT];
        // Loading the seconds restarts the prescaler, so the new second is a whole one.
        if (wr_fire && (i_bus.addr == ADDR_SEC) && !ctrl_reg[CTRL_ALARM_BIT]) begin
            presc_next = '0;
        end else if (i_osc_tick) begin
            presc_next = (presc_reg >= div_top) ? '0 : presc_reg + 22'h00_0001;
        end else begin
            presc_next = presc_reg;
        end
        // Ticks that land during an access wait in a small backlog.
        apply = !access && ((pend_reg != 4'h0) || tick);
        pend_next = pend_reg;
        if (tick && !apply && pend_reg != PEND_MAX) begin
            pend_next = pend_reg + 4'h1;
        end else if (apply && !tick) begin
            pend_next = pend_reg - 4'h1;
        end
    end

    // Time counters and alarm latches.
    always_comb begin
        time_next = time_reg;
        alarm_next = alarm_reg;
        sec_carry = apply && (time_reg.sec == 8'h59);
        min_carry = sec_carry && (time_reg.min == 8'h59);
        hr_carry = 1'b0;
        day_carry = 1'b0;
        hr_n = time_reg.hr;
        hr_inc = bcd_inc({2'b00, time_reg.hr[5:0]});
        mon_inc = bcd_inc({1'b0, time_reg.mon[6:0]});
        if (time_reg.hr[HR_12H_BIT]) begin
            hr_carry = (time_reg.hr[5:0] == 6'h11) && time_reg.hr[HR_PM_BIT];
            hr_n[5:0] = (time_reg.hr[5:0] == 6'h12) ? 6'h01 : hr_inc[5:0];
        end else begin
            hr_carry = (time_reg.hr[5:0] == 6'h23);
            hr_n[5:0] = hr_carry ? 6'h00 : hr_inc[5:0];
        end
        // The PM flag flips at the 11 and 23 boundaries whichever format runs.
        if (time_reg.hr[5:0] == 6'h11 || time_reg.hr[5:0] == 6'h23) begin
            hr_n[HR_PM_BIT] = !time_reg.hr[HR_PM_BIT];
        end
        day_carry = min_carry && hr_carry && (time_reg.day == days_in(time_reg.mon));
        if (apply) begin
            time_next.sec = sec_carry ? 8'h00 : bcd_inc(time_reg.sec);
        end
        if (sec_carry) begin
            time_next.min = min_carry ? 8'h00 : bcd_inc(time_reg.min);
        end
        if (min_carry) begin
            time_next.hr = hr_n;
        end
        if (min_carry && hr_carry) begin
            time_next.day = day_carry ? 8'h01 : bcd_inc(time_reg.day);
        end
        if (day_carry) begin
            time_next.mon[6:0] = (time_reg.mon[4:0] == 5'h12) ? 7'h01 : mon_inc[6:0];
        end
        if (wr_fire) begin
            unique case (i_bus.addr)
                ADDR_SEC: begin
                    if (ctrl_reg[CTRL_ALARM_BIT]) alarm_next.sec = i_bus.wdata;
                    else time_next.sec = i_bus.wdata;
                end
                ADDR_MIN: begin
                    if (ctrl_reg[CTRL_ALARM_BIT]) alarm_next.min = i_bus.wdata;
                    else time_next.min = i_bus.wdata;
                end
                ADDR_HR: begin
                    if (ctrl_reg[CTRL_ALARM_BIT]) alarm_next.hr = i_bus.wdata;
                    else time_next.hr = i_bus.wdata;
                end
                ADDR_DAY: time_next.day = i_bus.wdata;
                ADDR_MON: time_next.mon = i_bus.wdata;
                default: begin
                end
            endcase
        end
    end

    // Bus, control, clock output and interrupt status.
    always_comb begin
        unique case (ctrl_reg[7:4])
            4'h0: wave = 1'b0;
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC:
                wave = phase[ctrl_reg[7:4] + 4'h2];
            4'hD: wave = (time_reg.sec[6:4] >= 3'h3);
            4'hE: wave = (time_reg.min[6:4] >= 3'h3);
            4'hF: wave = time_reg.hr[HR_PM_BIT];
        endcase
        co_next = wave;
        co_fall = co_reg && !wave && (ctrl_reg[7:4] != 4'h0);
        // Only the rising edge of a match flags, so a held match flags once.
        match = ctrl_reg[CTRL_ALARM_BIT] && (time_reg.sec == alarm_reg.sec)
            && (time_reg.min == alarm_reg.min) && (time_reg.hr == alarm_reg.hr);
        match_q_next = match;
        alarm_rise = match && !match_q_reg;
        wr_q_next = access && i_bus.wr;
        ctrl_next = wr_ctrl ? i_bus.wdata : ctrl_reg;
        status_next = wr_ctrl ? 8'h00 : status_reg;
        if (alarm_rise) status_next[STAT_ALARM_BIT] = 1'b1;
        if (co_fall) status_next[STAT_CLKOUT_BIT] = 1'b1;
        irq_n_next = !(|status_next);
        rdata_next = rdata_reg;
        if (rd_fire) begin
            unique case (i_bus.addr)
                ADDR_SEC: rdata_next = time_reg.sec;
                ADDR_MIN: rdata_next = time_reg.min;
                ADDR_HR: rdata_next = time_reg.hr;
                ADDR_DAY: rdata_next = time_reg.day;
                ADDR_MON: rdata_next = time_reg.mon;
                ADDR_CTRL: rdata_next = status_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_reg <= CTRL_RESET;
            status_reg <= 8'h00;
            rdata_reg <= 8'h00;
            wr_q_reg <= 1'b0;
            irq_n_reg <= 1'b1;
            presc_reg <= '0;
            pend_reg <= 4'h0;
            time_reg <= {SEC_RESET, MIN_RESET, HR_RESET, DAY_RESET, MON_RESET};
            alarm_reg <= {SEC_RESET, MIN_RESET, HR_ALARM_RESET, DAY_RESET, MON_RESET};
            co_reg <= 1'b0;
            match_q_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            status_reg <= status_next;
            rdata_reg <= rdata_next;
            wr_q_reg <= wr_q_next;
            irq_n_reg <= irq_n_next;
            presc_reg <= presc_next;
            pend_reg <= pend_next;
            time_reg <= time_next;
            alarm_reg <= alarm_next;
            co_reg <= co_next;
            match_q_reg <= match_q_next;
        end
    end

    assign o_rdata = rdata_reg;
    // The data bus is driven only while a read is being served.
    assign o_rdata_oe = rd_fire;
    assign o_clkout = co_reg;
    assign o_irq_n = irq_n_reg;

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    // Timekeeping chain.
    stop_hold_a: assert property (
        !ctrl_reg[CTRL_RUN_BIT] && pend_reg == 4'h0 && !wr_fire |=> $stable(time_reg.sec))
        else $error("time advanced while stopped");
    freeze_a: assert property (
        access && !wr_fire |=> $stable(time_reg))
        else $error("time moved during access");
    sec_roll_a: assert property (
        apply && time_reg.sec == 8'h59 && !wr_fire |=> time_reg.sec == 8'h00)
        else $error("seconds did not roll over");
    pm_toggle_a: assert property (
        min_carry && time_reg.hr[5:0] == 6'h11
        |=> time_reg.hr[HR_PM_BIT] != $past(time_reg.hr[HR_PM_BIT]))
        else $error("PM flag did not invert");
    hr24_roll_a: assert property (
        min_carry && !time_reg.hr[HR_12H_BIT] && time_reg.hr[5:0] == 6'h23
        |=> time_reg.hr[5:0] == 6'h00)
        else $error("24-hour count did not wrap");
    hr12_wrap_a: assert property (
        min_carry && time_reg.hr[HR_12H_BIT] && time_reg.hr[5:0] == 6'h12
        |=> time_reg.hr[5:0] == 6'h01)
        else $error("12-hour count did not wrap");
    leap_day_a: assert property (
        min_carry && hr_carry && time_reg.mon[MON_LEAP_BIT] && time_reg.mon[4:0] == 5'h02
        && time_reg.day == 8'h28 |=> time_reg.day == 8'h29)
        else $error("leap February skipped its 29th");
    plain_feb_a: assert property (
        min_carry && hr_carry && !time_reg.mon[MON_LEAP_BIT] && time_reg.mon[4:0] == 5'h02
        && time_reg.day == 8'h28 |=> time_reg.day == 8'h01 && time_reg.mon[4:0] == 5'h03)
        else $error("plain February did not end on the 28th");
    leap_keep_a: assert property (
        day_carry |=> time_reg.mon[MON_LEAP_BIT] == $past(time_reg.mon[MON_LEAP_BIT]))
        else $error("month rollover changed the leap flag");

    // Bus and load steering.
    count_load_a: assert property (
        wr_fire && i_bus.addr == ADDR_MIN && !ctrl_reg[CTRL_ALARM_BIT]
        |=> time_reg.min == $past(i_bus.wdata))
        else $error("minutes write missed the counter");
    alarm_load_a: assert property (
        wr_fire && i_bus.addr == ADDR_HR && ctrl_reg[CTRL_ALARM_BIT]
        |=> alarm_reg.hr == $past(i_bus.wdata) && $stable(time_reg.hr))
        else $error("hours write missed the alarm latch");
    read_hide_a: assert property (
        rd_fire && i_bus.addr == ADDR_SEC |=> o_rdata == $past(time_reg.sec))
        else $error("read returned other than counter");
    rd_status_a: assert property (
        rd_fire && i_bus.addr == ADDR_CTRL |=> o_rdata == $past(status_reg))
        else $error("status read returned the wrong byte");
    pd_ignore_a: assert property (
        i_power_down |=> $stable(ctrl_reg))
        else $error("bus honoured in power-down");
    pd_quiet_a: assert property (
        i_power_down |-> !o_rdata_oe)
        else $error("data bus driven in power-down");

    // Interrupt and clock output.
    alarm_flag_a: assert property (
        alarm_rise |=> status_reg[STAT_ALARM_BIT] && !o_irq_n)
        else $error("alarm match not flagged");
    clkout_flag_a: assert property (
        co_fall |=> status_reg[STAT_CLKOUT_BIT] ##0 !o_irq_n)
        else $error("clock-out fall not flagged");
    ctrl_clear_a: assert property (
        wr_ctrl && !alarm_rise && !co_fall |=> status_reg == 8'h00 && o_irq_n)
        else $error("control write left status set");
    sticky_a: assert property (
        status_reg[STAT_ALARM_BIT] && !wr_ctrl |=> status_reg[STAT_ALARM_BIT])
        else $error("alarm flag dropped");
    status_low_a: assert property (
        status_reg[5:0] == 6'h00)
        else $error("unused status bits set");
    clkout_off_a: assert property (
        ctrl_reg[7:4] == 4'h0 |=> !o_clkout)
        else $error("clock output ran while disabled");

    alarm_c: cover property (alarm_rise);
    clkout_c: cover property (co_fall ##1 !o_irq_n);
    leap_day_c: cover property (min_carry && hr_carry && time_reg.day == 8'h29);
    backlog_c: cover property (pend_reg != 4'h0 ##1 apply);
    pm_flip_c: cover property (min_carry && time_reg.hr[5:0] == 6'h11);
endmodule // bcc_clock

// ### sim/bcc_host.sv
`timescale 1ns/1ps
module bcc_host (
    // Clock and mode.
    input wire logic i_mclk,
    input wire logic i_io_mode,
    // Bus towards the clock.
    output bcc_pkg::bcc_bus_t o_bus,
    input wire logic [7:0] i_rdata
);
    import bcc_pkg::*;
    initial o_bus = '0;
    // Released lines show the inverse of the last address and data.
    task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge i_mclk);
        o_bus <= {!i_io_mode, i_io_mode, !w, w, a, d};
        @(posedge i_mclk);
        if (!w) @(posedge i_mclk);
        q = i_rdata;
        o_bus <= {4'h0, ~a, ~d};
    endtask
endmodule // bcc_host

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import bcc_pkg::*;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_osc_tick = 1'b0;
    logic i_io_mode = 1'b0;
    logic i_power_down = 1'b0;
    bcc_bus_t bus;
    logic [7:0] o_rdata, q, v, m;
    logic o_rdata_oe, o_clkout, o_irq_n;
    int errors = 0;
    int total_checks = 0;
    int n;
    logic [31:0] seed = 32'h0000_fd44;

    always #50 i_mclk = ~i_mclk;

    bcc_clock u_bcc_clock (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_osc_tick(i_osc_tick),
        .i_io_mode(i_io_mode), .i_power_down(i_power_down), .i_bus(bus),
        .o_rdata(o_rdata), .o_rdata_oe(o_rdata_oe), .o_clkout(o_clkout), .o_irq_n(o_irq_n));
    bcc_host u_bcc_host (.i_mclk(i_mclk), .i_io_mode(i_io_mode), .o_bus(bus),
        .i_rdata(o_rdata));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] bcd(input int x);
        return 8'(((x / 10) << 4) | (x % 10));
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_bcc_host.access(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        u_bcc_host.access(1'b0, a, 8'h00, q);
        chk(q, exp);
        chk({7'h0, o_rdata_oe}, 8'h01);
    endtask
    // Reads addresses 2 to 7 and compares them with six packed bytes.
    task automatic rd_all(input logic [47:0] e);
        for (int a = 2; a < 8; a++) begin
            rd_chk(3'(a), e[47 - 8 * (a - 2) -: 8]);
        end
    endtask
    task automatic wrap_up();
        $display("Checks made %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge i_mclk);
        i_resetn <= 1'b1;
        i_osc_tick <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd_chk(3'(a), (a == 5 || a == 6) ? 8'h01 : 8'h00);
        end
        v = bcd(int'(rnd() % 28) + 1);
        wr(ADDR_DAY, v);
        rd_chk(ADDR_DAY, v);
        i_io_mode <= 1'b1;
        m = bcd(int'(rnd() % 12) + 1);
        m[7] = 1'(rnd() % 2);
        wr(ADDR_MON, m);
        rd_chk(ADDR_MON, m);
        i_io_mode <= 1'b0;
        i_power_down <= 1'b1;
        wr(ADDR_DAY, v ^ 8'h01);
        i_power_down <= 1'b0;
        rd_chk(ADDR_DAY, v);
        for (int c = 1; c <= 8; c++) begin
            wr(ADDR_CTRL, {4'(c), 4'h4});
            // Skip the sample still launched under the previous clock select.
            @(posedge i_mclk);
            n = 0;
            repeat (16 << c) begin
                @(posedge i_mclk);
                n += o_clkout;
            end
            chk(8'(n - (8 << c)), 8'h00);
            chk({7'h0, o_irq_n}, 8'h00);
            rd_chk(ADDR_CTRL, 8'h40);
        end
        wr(ADDR_CTRL, 8'h04);
        wr(ADDR_CTRL, 8'h04);
        n = 0;
        repeat (64) begin
            @(posedge i_mclk);
            n += o_clkout + !o_irq_n;
        end
        chk(8'(n), 8'h00);
        rd_chk(ADDR_CTRL, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_MIN, 8'h59);
        wr(ADDR_HR, 8'hA3);
        wr(ADDR_DAY, 8'h28);
        wr(ADDR_MON, 8'h82);
        wr(ADDR_SEC, 8'h59);
        wr(ADDR_CTRL, 8'h0C);
        for (int a = 2; a < 5; a++) begin
            wr(3'(a), 8'h00);
        end
        rd_chk(ADDR_SEC, 8'h59);
        n = 0;
        while (o_irq_n !== 1'b0 && n < 40000) begin
            @(posedge i_mclk);
            n++;
        end
        chk(8'(n == 40000), 8'h00);
        if (n == 40000) wrap_up();
        rd_all(48'h0000_0029_8280);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_HR, 8'h51);
        wr(ADDR_MIN, 8'h59);
        wr(ADDR_SEC, 8'h59);
        wr(ADDR_CTRL, 8'hF4);
        repeat (32800) @(posedge i_mclk);
        chk({7'h0, o_clkout}, 8'h01);
        rd_all(48'h0000_D229_8200);
        wrap_up();
    end
endmodule // testbench
